/* hdl/frax_alu.v */
`include "frax_consts.vh"

// combinational and/add unit with flag outputs
module frax_alu
(
    input  wire [7:0] acc,
    input  wire [7:0] fval,
    input  wire       sel_add,
    output reg  [7:0] result,
    output reg        carry,
    output reg        nib_carry,
    output reg        zero
);

    reg [8:0] sum;
    reg [4:0] low_sum;

    ////////////////////////////////////////////////////////////////////////
    // the nibble carry comes from a separate low-half sum so it needs no decode
    always @*
    begin
        sum       = {1'h0, acc} + {1'h0, fval};
        low_sum   = {1'h0, acc[3:0]} + {1'h0, fval[3:0]};
        result    = sel_add ? sum[7:0] : (acc & fval);
        carry     = sum[8];
        nib_carry = low_sum[4];
        zero      = (result == 8'h00);
    end

endmodule // frax_alu

/* hdl/frax_consts.vh */
`ifndef FRAX_CONSTS_VH
`define FRAX_CONSTS_VH
// instruction word layout
`define FRAX_IW_WIDTH     14
`define FRAX_OPC_HI       13
`define FRAX_OPC_LO       8
`define FRAX_DEST_BIT     7
`define FRAX_ADDR_HI      6
`define FRAX_ADDR_LO      0
// upper opcode field patterns (bits 13..8)
`define FRAX_OPC_AND      6'h05
`define FRAX_OPC_ADD      6'h07
// destination select values
`define FRAX_DEST_ACC     1'h0
`define FRAX_DEST_FILE    1'h1
// reset values
`define FRAX_ACC_RST      8'h00
`define FRAX_FLAG_RST     1'h0
`define FRAX_PULSE_RST    1'h0
`define FRAX_WR_ADDR_RST  7'h00
`define FRAX_WR_DATA_RST  8'h00
`endif

/* hdl/frax_exec.v */
// Contract
// - opcode 0101 ands the accumulator with the addressed file register and updates only the zero flag.
// - opcode 0111 adds accumulator and file register into 8 bits and updates carry, nibble carry and zero.
// - with destination select 0 the result goes to the accumulator and the file register is untouched.
// - with destination select 1 the result goes to the file register and the accumulator is untouched.
`include "frax_consts.vh"

module frax_exec
(
    clock,
    rst,
    instr_valid,
    instr_word,
    file_addr,
    file_rdata,
    file_wr_en,
    file_wr_addr,
    file_wr_data,
    acc_out,
    carry_flag,
    nibble_carry_flag,
    zero_flag,
    done
);
    input  wire                       clock;
    input  wire                       rst;
    input  wire                       instr_valid;
    input  wire [`FRAX_IW_WIDTH-1:0]  instr_word;
    output wire [6:0]                 file_addr;
    input  wire [7:0]                 file_rdata;
    output reg                        file_wr_en;
    output reg  [6:0]                 file_wr_addr;
    output reg  [7:0]                 file_wr_data;
    output reg  [7:0]                 acc_out;
    output reg                        carry_flag;
    output reg                        nibble_carry_flag;
    output reg                        zero_flag;
    output reg                        done;

    ////////////////////////////////////////////////////////////////////////
    // field widths taken from the word layout, so a layout change moves them too
    localparam OPC_W  = `FRAX_OPC_HI - `FRAX_OPC_LO + 1;
    localparam ADDR_W = `FRAX_ADDR_HI - `FRAX_ADDR_LO + 1;

    // decoded instruction fields
    wire [OPC_W-1:0]  opc;
    wire              dest;
    wire              is_and;
    wire              is_add;
    wire              exec;
    wire              to_file;
    wire              to_acc;

    // combinational unit outputs
    wire [7:0]        alu_res;
    wire              alu_c;
    wire              alu_nc;
    wire              alu_z;

    // next values of the registered outputs; every output but the read address
    // comes straight from a flip-flop so the far side sees clean levels
    reg  [7:0]        acc_d;
    reg               carry_d;
    reg               nib_carry_d;
    reg               zero_d;
    reg               wr_en_d;
    reg  [ADDR_W-1:0] wr_addr_d;
    reg  [7:0]        wr_data_d;
    reg               done_d;

    ////////////////////////////////////////////////////////////////////////
    // opcode compare, shared by both instruction decodes
    function opc_match;
        input [OPC_W-1:0] code;
        input [OPC_W-1:0] pattern;
        begin
            opc_match = (code == pattern);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // field decode; the read address is combinational so the file read lands
    // in the same cycle as the word, which is what keeps execution to one cycle
    assign opc       = instr_word[`FRAX_OPC_HI:`FRAX_OPC_LO];
    assign dest      = instr_word[`FRAX_DEST_BIT];
    assign file_addr = instr_word[`FRAX_ADDR_HI:`FRAX_ADDR_LO];
    assign is_and    = opc_match(opc, `FRAX_OPC_AND);
    assign is_add    = opc_match(opc, `FRAX_OPC_ADD);

    // only a valid word with one of the two opcodes executes; any other word
    // belongs to another unit and must leave this datapath alone
    assign exec      = instr_valid & (is_and | is_add);
    assign to_file   = exec & (dest == `FRAX_DEST_FILE);
    assign to_acc    = exec & (dest == `FRAX_DEST_ACC);

    ////////////////////////////////////////////////////////////////////////
    // shared and/add unit; it always computes both, the opcode only picks
    frax_alu u_alu
    (
        .acc       (acc_out),
        .fval      (file_rdata),
        .sel_add   (is_add),
        .result    (alu_res),
        .carry     (alu_c),
        .nib_carry (alu_nc),
        .zero      (alu_z)
    );

    ////////////////////////////////////////////////////////////////////////
    // accumulator next value: loaded only when the result is routed to it
    always @*
    begin
        acc_d = acc_out;
        if (to_acc)
            acc_d = alu_res;
    end

    ////////////////////////////////////////////////////////////////////////
    // flag next values; zero follows both instructions, the two carries only
    // the add, so a logical and never disturbs a carry left by an earlier add
    always @*
    begin
        carry_d     = carry_flag;
        nib_carry_d = nibble_carry_flag;
        zero_d      = zero_flag;
        if (exec)
            zero_d = alu_z;
        if (exec & is_add)
        begin
            carry_d     = alu_c;
            nib_carry_d = alu_nc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write-back port next values; address and data follow every executed
    // word so they always show the last result, and the enable alone says
    // whether the file register is written; the write lands one cycle after
    // the instruction, so a read of the same address in that cycle must be
    // served by the register file's own bypass
    always @*
    begin
        wr_en_d   = to_file;
        wr_addr_d = file_wr_addr;
        wr_data_d = file_wr_data;
        if (exec)
        begin
            wr_addr_d = file_addr;
            wr_data_d = alu_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion strobe: one pulse per executed word, so one word per cycle
    always @*
    begin
        done_d = exec;
    end

    ////////////////////////////////////////////////////////////////////////
    // accumulator register; it feeds the unit in the same cycle, so a result
    // is usable by the very next word
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            acc_out <= `FRAX_ACC_RST;
        end
        else
        begin
            acc_out <= acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flag registers; they hold across every word that does not execute
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            carry_flag        <= `FRAX_FLAG_RST;
            nibble_carry_flag <= `FRAX_FLAG_RST;
            zero_flag         <= `FRAX_FLAG_RST;
        end
        else
        begin
            carry_flag        <= carry_d;
            nibble_carry_flag <= nib_carry_d;
            zero_flag         <= zero_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write-back port registers; the enable is a one-cycle pulse
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            file_wr_en   <= `FRAX_PULSE_RST;
            file_wr_addr <= `FRAX_WR_ADDR_RST;
            file_wr_data <= `FRAX_WR_DATA_RST;
        end
        else
        begin
            file_wr_en   <= wr_en_d;
            file_wr_addr <= wr_addr_d;
            file_wr_data <= wr_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion strobe register; the fetch side may count it, but it never
    // gates the next word, which may follow in the very next cycle
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            done <= `FRAX_PULSE_RST;
        end
        else
        begin
            done <= done_d;
        end
    end

endmodule // frax_exec

/* sim/frax_exec_monitor.sv */
module frax_exec_monitor (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [6:0]  file_addr,
    input wire logic [7:0]  file_rdata,
    input wire logic        file_wr_en,
    input wire logic [6:0]  file_wr_addr,
    input wire logic [7:0]  file_wr_data,
    input wire logic [7:0]  acc_out,
    input wire logic        carry_flag,
    input wire logic        nibble_carry_flag,
    input wire logic        zero_flag,
    input wire logic        done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // an instruction this block executes
    wire go = instr_valid && (instr_word[13:8] == 6'h05 || instr_word[13:8] == 6'h07);
    and_flags_a: assert property (go && !instr_word[9] |=>
        zero_flag == ~|($past(acc_out) & $past(file_rdata)) && $stable(carry_flag) && $stable(nibble_carry_flag))
        else $error("and flags wrong");
    and_result_a: assert property (go && !instr_word[9] |=>
        (file_wr_en ? file_wr_data : acc_out) == ($past(acc_out) & $past(file_rdata))) else $error("and result wrong");
    add_sum_a: assert property (go && instr_word[9] |=>
        {carry_flag, file_wr_en ? file_wr_data : acc_out} == {1'b0, $past(acc_out)} + $past(file_rdata)
        && nibble_carry_flag == ($past(acc_out[3:0]) + $past(file_rdata[3:0]) > 15)) else $error("add result wrong");
    dest_acc_a: assert property (go && !instr_word[7] |=> !file_wr_en && done) else $error("acc write bad");
    dest_file_a: assert property (go && instr_word[7] |=>
        file_wr_en && file_wr_addr == $past(instr_word[6:0]) && $stable(acc_out)) else $error("file write bad");
    read_addr_a: assert property (file_addr == instr_word[6:0]) else $error("read address wrong");
    idle_hold_a: assert property (!go |=> !done && !file_wr_en && $stable(acc_out)
        && $stable(carry_flag) && $stable(nibble_carry_flag) && $stable(zero_flag)) else $error("idle change");
endmodule // frax_exec_monitor

/* sim/frax_file_model.sv */
module frax_file_model (
    input  wire logic       clock,
    input  wire logic       we,
    input  wire logic [6:0] ra,
    input  wire logic [6:0] wa,
    input  wire logic [7:0] wd,
    output logic [7:0]      rd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [128];
    // write lands a cycle late, so forward it to a back-to-back read
    assign rd = (we && wa == ra) ? wd : mem[ra];
    always @(posedge clock) if (we) mem[wa] <= wd;
endmodule // frax_file_model

/* sim/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 0, rst = 1, instr_valid = 0;
    logic [13:0] instr_word = 14'h0000;
    logic [6:0]  file_addr, file_wr_addr;
    logic [7:0]  file_rdata, file_wr_data, acc_out;
    logic        file_wr_en, carry_flag, nibble_carry_flag, zero_flag, done;
    int          err_count = 0, n_checks = 0;
    always #25 clock = ~clock;
    frax_exec i_dut (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
        .file_addr(file_addr), .file_rdata(file_rdata), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
        .file_wr_data(file_wr_data), .acc_out(acc_out), .carry_flag(carry_flag),
        .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag), .done(done));
    frax_file_model i_mem (.clock(clock), .we(file_wr_en), .ra(file_addr), .wa(file_wr_addr), .wd(file_wr_data),
        .rd(file_rdata));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task stop_test;
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one word held over one edge, then a look at state and write port; valid stays up,
    // so calls in a row give back-to-back words, and idle drops it again
    task op(input logic [5:0] o, input logic d, input logic [6:0] a, input logic [15:0] st, wr);
        instr_valid = 1;
        instr_word = {o, d, a};
        @(posedge clock) #5;
        chk({9'h000, file_addr}, {9'h000, a});
        chk({4'h0, acc_out, carry_flag, nibble_carry_flag, zero_flag, done}, st);
        chk({file_wr_en, file_wr_addr, file_wr_data}, wr);
    endtask
    // valid low with the last word still present: nothing changes, both pulses fall
    task idle(input logic [15:0] st, wr);
        instr_valid = 0;
        @(posedge clock) #5;
        chk({4'h0, acc_out, carry_flag, nibble_carry_flag, zero_flag, done}, st);
        chk({file_wr_en, file_wr_addr, file_wr_data}, wr);
    endtask
    // write address and data follow every executed word, the enable only file writes
    task t_add_dest;
        op(6'h07, 1'h0, 7'h01, 16'h0171, 16'h0117);
        op(6'h07, 1'h1, 7'h05, 16'h0171, 16'h85d9);
        idle(16'h0170, 16'h05d9);
    endtask
    // the second and reads the address the first has just written, through the bypass
    task t_and_dest;
        op(6'h05, 1'h1, 7'h05, 16'h0171, 16'h8511);
        op(6'h05, 1'h0, 7'h05, 16'h0111, 16'h0511);
        idle(16'h0110, 16'h0511);
    endtask
    task t_carry_hold;
        op(6'h07, 1'h0, 7'h02, 16'h000f, 16'h0200);
        op(6'h05, 1'h0, 7'h05, 16'h000f, 16'h0500);
        op(6'h06, 1'h0, 7'h05, 16'h000e, 16'h0500);
        idle(16'h000e, 16'h0500);
    endtask
    // reset in mid-run clears everything; the word right after release executes, and the next one sets nibble carry alone
    task t_reset;
        rst = 1;
        @(posedge clock) #5;
        chk({4'h0, acc_out, carry_flag, nibble_carry_flag, zero_flag, done}, 16'h0000);
        chk({file_wr_en, file_wr_addr, file_wr_data}, 16'h0000);
        rst = 0;
        op(6'h07, 1'h0, 7'h01, 16'h0171, 16'h0117);
        op(6'h07, 1'h1, 7'h03, 16'h0175, 16'h8320);
        idle(16'h0174, 16'h0320);
    endtask
    initial
    begin
        repeat (20) @(posedge clock);
        #5 rst = 0;
        i_mem.mem[1] = 8'h17;
        i_mem.mem[2] = 8'hef;
        i_mem.mem[3] = 8'h09;
        i_mem.mem[5] = 8'hc2;
        t_add_dest();
        t_and_dest();
        t_carry_hold();
        t_reset();
        stop_test();
    end
endmodule // tb_top
bind frax_exec frax_exec_monitor i_mon (.clock(clock), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_addr(file_addr), .file_rdata(file_rdata), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .acc_out(acc_out), .carry_flag(carry_flag),
    .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag), .done(done));
